/* File: design/fpsc_params.svh */
`ifndef FPSC_PARAMS_SVH
`define FPSC_PARAMS_SVH

// ==========================================================
// link word layout and clock
// ==========================================================
`define FPSC_LINK_FREQ_KHZ 12500
`define FPSC_CLK_FREQ_KHZ 125000
`define FPSC_BYTE_W 8
`define FPSC_WORD_W 10

// ==========================================================
// fixed outgoing control codes (flag 1)
// ==========================================================
`define FPSC_CODE_JK 8'hdd
`define FPSC_CODE_IDLE 8'haa
`define FPSC_NIB_RESET 4'h6
`define FPSC_NIB_SET 4'h7
`define FPSC_NIB_TERM 4'h5
`define FPSC_NIB_ED 4'h5
`define FPSC_NIB_JK 4'hd
`define FPSC_NIB_ZERO 4'h0

// ==========================================================
// transmit buffer
// ==========================================================
`define FPSC_FIFO_DEPTH 32
`define FPSC_FIFO_AW 5

`endif

/* File: design/fpsc_pkg.sv */
package fpsc_pkg;

    // outgoing request kinds
    typedef enum logic [2:0] {
        FPSC_TX_DATA = 3'b000,
        FPSC_TX_JK = 3'b001,
        FPSC_TX_IDLE = 3'b010,
        FPSC_TX_FS = 3'b011,
        FPSC_TX_FS_RPT = 3'b100,
        FPSC_TX_ED = 3'b101
    } fpsc_tx_kind_t;

    // incoming byte classes
    typedef enum logic [3:0] {
        FPSC_RX_DATA = 4'b0000,
        FPSC_RX_JK = 4'b0001,
        FPSC_RX_IDLE = 4'b0010,
        FPSC_RX_INVALID = 4'b0011,
        FPSC_RX_FS = 4'b0100,
        FPSC_RX_ED = 4'b0101,
        FPSC_RX_MIXED = 4'b0110,
        FPSC_RX_DATA_IDLE = 4'b0111,
        FPSC_RX_VIOL = 4'b1000
    } fpsc_rx_class_t;

endpackage

/* File: design/fpsc_codec.sv */
`timescale 1ns/1ps
`include "fpsc_params.svh"

// ==========================================================
// request buffer: plain synchronous fifo
// ==========================================================
module fpsc_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = `FPSC_FIFO_DEPTH,
    parameter int AW = `FPSC_FIFO_AW
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];    // storage array
    logic [AW-1:0] wr_ptr_reg;        // next slot to write
    logic [AW-1:0] rd_ptr_reg;        // next slot to read
    logic [AW:0] count_reg;           // words held, one bit wider
    logic push;
    logic pop;
    logic [AW:0] count_next;          // occupancy after this edge

    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o && clk_en_i;
    assign pop = out_valid_o && out_ready_i && clk_en_i;

    // occupancy next value; ready is derived from it one edge early
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // storage has no reset; only written slots are ever read
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and occupancy
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            // ready registered so the port comes straight from a flop
            in_ready_o <= (count_next != (AW+1)'(DEPTH));
        end
    end
endmodule

// Function
// - one pair byte per byte clock, both ways
// - outgoing flag low data, high control
// - outgoing parity odd over ten bits
// - incoming flag picks data or control decode
// - data byte with bad parity is violation
// - data pair passes unchanged, high nibble first
// - start delimiter on high nibble only
// - idle only in active/idle line state
// - remaining control codes decode or violate
// - never send mixed control/data pairs
// - fixed start delimiter and idle codes
// - fixed ending delimiter codes
// - frame status codes with odd parity
// - word is nine-bit code plus parity
// - forward, never originate RS RT ST
module fpsc_codec (
    // clock, enable and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // incoming link from the physical layer
    input wire logic rx_pair_parity_i,
    input wire logic rx_pair_ctrl_flag_i,
    input wire logic [7:0] rx_pair_byte_i,
    input wire logic active_line_state_i,
    input wire logic idle_line_state_i,
    // decoded incoming stream
    output logic [7:0] rx_byte_o,
    output fpsc_pkg::fpsc_rx_class_t rx_class_o,
    output logic line_invalid_indication_o,
    output logic rx_code_violation_o,
    // outgoing request from the ring logic
    input wire logic tx_req_valid_i,
    output logic tx_req_ready_o,
    input wire fpsc_pkg::fpsc_tx_kind_t tx_req_kind_i,
    input wire logic [7:0] tx_req_byte_i,
    input wire logic tx_hold_i,
    // outgoing link to the physical layer
    output logic tx_pair_parity_o,
    output logic tx_pair_ctrl_flag_o,
    output logic [7:0] tx_pair_byte_o,
    output logic tx_reject_o
);
    // ==========================================================
    // decode helpers
    // ==========================================================

    // odd parity bit over flag and byte
    function automatic logic odd_par(input logic flag, input logic [7:0] b);
        odd_par = ~^{flag, b};
    endfunction

    // classify one incoming link word
    function automatic fpsc_pkg::fpsc_rx_class_t classify(
        input logic par,
        input logic flag,
        input logic [7:0] b,
        input logic line_ok
    );
        logic [3:0] hi;
        logic [3:0] lo;
        hi = b[7:4];
        lo = b[3:0];
        if (!flag) begin
            // flag low selects data decoding
            if (par != odd_par(flag, b)) begin
                classify = fpsc_pkg::FPSC_RX_VIOL;
            end else begin
                classify = fpsc_pkg::FPSC_RX_DATA;
            end
        end else if (hi == `FPSC_NIB_JK) begin
            classify = fpsc_pkg::FPSC_RX_JK;    // low nibble ignored
        end else if (hi[2:0] == 3'b011 && (lo[2] || lo[1])) begin
            // invalid code outranks the idle overlap at 1011
            classify = fpsc_pkg::FPSC_RX_INVALID;
        end else if (hi[3:2] == 2'b10) begin
            // idle only counts as idle in active or idle line state
            classify = line_ok ? fpsc_pkg::FPSC_RX_IDLE
                               : fpsc_pkg::FPSC_RX_INVALID;
        end else if (hi == `FPSC_NIB_ZERO && lo[3:2] == 2'b10) begin
            classify = fpsc_pkg::FPSC_RX_DATA_IDLE;
        end else if (hi == `FPSC_NIB_ZERO && lo == `FPSC_NIB_TERM) begin
            classify = fpsc_pkg::FPSC_RX_MIXED;
        end else if (hi == `FPSC_NIB_RESET || hi == `FPSC_NIB_SET) begin
            classify = fpsc_pkg::FPSC_RX_FS;
        end else if (hi == `FPSC_NIB_ED) begin
            classify = fpsc_pkg::FPSC_RX_ED;
        end else begin
            classify = fpsc_pkg::FPSC_RX_VIOL;
        end
    endfunction

    // legal second symbol of a status or delimiter pair
    function automatic logic lo_ok(input logic [3:0] lo);
        lo_ok = (lo == `FPSC_NIB_RESET) || (lo == `FPSC_NIB_SET) ||
                (lo == `FPSC_NIB_TERM);
    endfunction

    // ==========================================================
    // receive path
    // ==========================================================
    logic rx_par_reg;          // captured parity bit
    logic rx_flag_reg;         // captured control flag
    logic [7:0] rx_b_reg;      // captured pair byte
    logic rx_line_ok_reg;      // line state allowed idle
    fpsc_pkg::fpsc_rx_class_t rx_class_next;

    // capture the link word; partner shares our byte clock
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_par_reg <= 1'b0;
            rx_flag_reg <= 1'b1;
            rx_b_reg <= `FPSC_CODE_IDLE;
            rx_line_ok_reg <= 1'b0;
        end else if (clk_en_i) begin
            rx_par_reg <= rx_pair_parity_i;
            rx_flag_reg <= rx_pair_ctrl_flag_i;
            rx_b_reg <= rx_pair_byte_i;
            rx_line_ok_reg <= active_line_state_i || idle_line_state_i;
        end
    end

    // nine code bits, parity and line state give the class
    always_comb begin
        rx_class_next = classify(rx_par_reg, rx_flag_reg, rx_b_reg,
                                 rx_line_ok_reg);
    end

    // decoded outputs, one stage after capture
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_byte_o <= `FPSC_CODE_IDLE;
            rx_class_o <= fpsc_pkg::FPSC_RX_INVALID;
            line_invalid_indication_o <= 1'b0;
            rx_code_violation_o <= 1'b0;
        end else if (clk_en_i) begin
            rx_byte_o <= rx_b_reg;    // byte passes unchanged
            rx_class_o <= rx_class_next;
            line_invalid_indication_o <=
                (rx_class_next == fpsc_pkg::FPSC_RX_INVALID);
            rx_code_violation_o <=
                (rx_class_next == fpsc_pkg::FPSC_RX_VIOL);
        end
    end

    // ==========================================================
    // transmit request buffer
    // ==========================================================
    logic buf_valid;            // a request waits
    logic buf_ready;            // encoder takes it
    logic [10:0] buf_data;      // kind and byte
    fpsc_pkg::fpsc_tx_kind_t cur_kind;
    logic [7:0] cur_byte;

    // hold stalls the drain so bursts really fill the buffer
    assign buf_ready = !tx_hold_i;
    assign cur_kind = fpsc_pkg::fpsc_tx_kind_t'(buf_data[10:8]);
    assign cur_byte = buf_data[7:0];

    fpsc_fifo #(
        .WIDTH(11),
        .DEPTH(`FPSC_FIFO_DEPTH),
        .AW(`FPSC_FIFO_AW)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .in_valid_i(tx_req_valid_i),
        .in_ready_o(tx_req_ready_o),
        .in_data_i({tx_req_kind_i, tx_req_byte_i}),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_ready),
        .out_data_o(buf_data)
    );

    // ==========================================================
    // transmit encoder
    // ==========================================================
    logic tx_flag_next;
    logic [7:0] tx_byte_next;
    logic tx_rej_next;
    logic [3:0] req_hi;
    logic [3:0] req_lo;

    assign req_hi = cur_byte[7:4];
    assign req_lo = cur_byte[3:0];

    // pick the outgoing code; idle fills every empty slot
    always_comb begin
        tx_flag_next = 1'b1;
        tx_byte_next = `FPSC_CODE_IDLE;
        tx_rej_next = 1'b0;
        if (buf_valid && buf_ready) begin
            case (cur_kind)
                fpsc_pkg::FPSC_TX_DATA: begin
                    tx_flag_next = 1'b0;
                    tx_byte_next = cur_byte;
                end
                fpsc_pkg::FPSC_TX_JK: begin
                    tx_byte_next = `FPSC_CODE_JK;
                end
                fpsc_pkg::FPSC_TX_IDLE: begin
                    tx_byte_next = `FPSC_CODE_IDLE;
                end
                fpsc_pkg::FPSC_TX_FS, fpsc_pkg::FPSC_TX_FS_RPT: begin
                    // status pairs: R/S then R/S/T when repeated, only RR or SS when originated, else refused
                    if ((req_hi == `FPSC_NIB_RESET || req_hi == `FPSC_NIB_SET)
                        && lo_ok(req_lo)
                        && (cur_kind == fpsc_pkg::FPSC_TX_FS_RPT
                            || req_lo == req_hi)) begin
                        tx_byte_next = cur_byte;
                    end else begin
                        tx_rej_next = 1'b1;
                    end
                end
                fpsc_pkg::FPSC_TX_ED: begin
                    // ending delimiter with R, S or T second symbol
                    if (lo_ok(req_lo)) begin
                        tx_byte_next = {`FPSC_NIB_ED, req_lo};
                    end else begin
                        tx_rej_next = 1'b1;
                    end
                end
                default: begin
                    // no mixed pair kind exists; unknown kinds refused
                    tx_rej_next = 1'b1;
                end
            endcase
        end
    end

    // drive the link word, idle while in reset
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_pair_ctrl_flag_o <= 1'b1;
            tx_pair_byte_o <= `FPSC_CODE_IDLE;
            tx_pair_parity_o <= 1'b0;    // idle is odd already
        end else if (clk_en_i) begin
            tx_pair_ctrl_flag_o <= tx_flag_next;
            tx_pair_byte_o <= tx_byte_next;
            tx_pair_parity_o <= odd_par(tx_flag_next, tx_byte_next);
        end
    end

    // refused request flag, one cycle per refused word
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_reject_o <= 1'b0;
        end else if (clk_en_i) begin
            tx_reject_o <= tx_rej_next;
        end
    end
endmodule

/* File: verification/fpsc_phy_model.sv */
`timescale 1ns/1ps
// =====
// physical layer side: drives the indicate stream
// =====
module fpsc_phy_model (
    // clock
    input wire logic ref_clk_i,
    // commanded word and line state
    input wire logic ctl_i,
    input wire logic [7:0] byte_i,
    input wire logic bad_i,
    input wire logic [1:0] ls_i,
    // indicate pins
    output logic rx_pair_parity_o,
    output logic rx_pair_ctrl_flag_o,
    output logic [7:0] rx_pair_byte_o,
    output logic active_line_state_o,
    output logic idle_line_state_o
);
    // one aligned word every byte clock, no gaps
    always_ff @(posedge ref_clk_i) begin
        rx_pair_ctrl_flag_o <= ctl_i;
        rx_pair_byte_o <= byte_i;
        // odd parity unless a fault is ordered
        rx_pair_parity_o <= ~^{ctl_i, byte_i} ^ bad_i;
        active_line_state_o <= ls_i[1];
        idle_line_state_o <= ls_i[0];
    end
endmodule

/* File: verification/fpsc_checker.sv */
`timescale 1ns/1ps
// =====
// pin level checker
// =====
module fpsc_checker (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // incoming link
    input wire logic rx_pair_parity_i,
    input wire logic rx_pair_ctrl_flag_i,
    input wire logic [7:0] rx_pair_byte_i,
    input wire logic active_line_state_i,
    input wire logic idle_line_state_i,
    // decode
    input wire logic [7:0] rx_byte_o,
    input wire fpsc_pkg::fpsc_rx_class_t rx_class_o,
    input wire logic line_invalid_indication_o,
    // outgoing link
    input wire logic tx_pair_parity_o,
    input wire logic tx_pair_ctrl_flag_o,
    input wire logic [7:0] tx_pair_byte_o,
    input wire logic tx_reject_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [9:0] txw; // whole outgoing word
    logic odd; // incoming word parity good
    logic [3:0] hi; // first incoming symbol
    logic c; // incoming control flag
    logic lok; // line state allows idle
    assign txw = {tx_pair_parity_o, tx_pair_ctrl_flag_o, tx_pair_byte_o};
    assign odd = ^{rx_pair_parity_i, rx_pair_ctrl_flag_i, rx_pair_byte_i};
    assign hi = rx_pair_byte_i[7:4];
    assign c = rx_pair_ctrl_flag_i;
    assign lok = active_line_state_i | idle_line_state_i;
    // capture then decode: two enabled edges
    sequence s_take(x);
        clk_en_i && x ##1 clk_en_i;
    endsequence
    a_tx_odd_par: assert property (^txw)
        else $error("tx parity even");
    a_rx_bad_par: assert property (s_take(!c && !odd) |=>
        rx_class_o == fpsc_pkg::FPSC_RX_VIOL) else $error("bad parity kept");
    a_rx_data_pass: assert property (s_take(!c && odd) |=>
        rx_class_o == fpsc_pkg::FPSC_RX_DATA && rx_byte_o == $past(rx_pair_byte_i, 2))
        else $error("data pair lost");
    a_rx_start_del: assert property (s_take(c && hi == 4'hd) |=>
        rx_class_o == fpsc_pkg::FPSC_RX_JK) else $error("start missed");
    a_rx_idle_ok: assert property (s_take(c && hi[3:2] == 2'b10 && lok &&
        !(hi == 4'hb && rx_pair_byte_i[2:1] != 2'b00)) |=>
        rx_class_o == fpsc_pkg::FPSC_RX_IDLE) else $error("idle missed");
    a_rx_idle_bad: assert property (s_take(c && hi[3:2] == 2'b10 && !lok) |=>
        line_invalid_indication_o) else $error("invalid missed");
    a_rx_fstat: assert property (s_take(c && hi[3:1] == 3'b011) |=>
        rx_class_o == fpsc_pkg::FPSC_RX_FS) else $error("status missed");
    a_tx_ctrl_set: assert property (tx_pair_ctrl_flag_o |->
        tx_pair_byte_o inside {8'hdd, 8'haa, 8'h66, 8'h67, 8'h65, 8'h77, 8'h76, 8'h75,
        8'h56, 8'h57, 8'h55}) else $error("tx control code bad");
    a_reject_idle: assert property (tx_reject_o |-> txw == 10'h1aa)
        else $error("refused slot not idle");
    a_reset_idle: assert property ($rose(resetn_i) |-> txw == 10'h1aa)
        else $error("no idle after reset");
endmodule

bind fpsc_codec fpsc_checker u_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .clk_en_i(clk_en_i), .rx_pair_parity_i(rx_pair_parity_i),
    .rx_pair_ctrl_flag_i(rx_pair_ctrl_flag_i), .rx_pair_byte_i(rx_pair_byte_i),
    .active_line_state_i(active_line_state_i), .idle_line_state_i(idle_line_state_i),
    .rx_byte_o(rx_byte_o), .rx_class_o(rx_class_o),
    .line_invalid_indication_o(line_invalid_indication_o),
    .tx_pair_parity_o(tx_pair_parity_o), .tx_pair_ctrl_flag_o(tx_pair_ctrl_flag_o),
    .tx_pair_byte_o(tx_pair_byte_o), .tx_reject_o(tx_reject_o));

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    // =====
    // pins, model commands, counters
    // =====
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic vld = 1'b0; // request valid
    logic hold = 1'b0; // drain stall
    logic en = 1'b1; // clock enable
    logic [7:0] rb = 8'h00; // request byte
    fpsc_pkg::fpsc_tx_kind_t rk = fpsc_pkg::FPSC_TX_DATA;
    logic mc = 1'b1; // model flag, byte, fault, line state
    logic [7:0] mb = 8'haa;
    logic mbad = 1'b0;
    logic [1:0] mls = 2'b11;
    logic rp, rc, active_line_state, idle_line_state, rdy, tp, tc, rej, inv, vio;
    logic [7:0] rxb, rxo, txb;
    fpsc_pkg::fpsc_rx_class_t cls;
    int error_cnt = 0;
    int checks_done = 0;
    always #4 clk = ~clk;
    fpsc_phy_model u_phy (.ref_clk_i(clk), .ctl_i(mc), .byte_i(mb), .bad_i(mbad), .ls_i(mls),
        .rx_pair_parity_o(rp), .rx_pair_ctrl_flag_o(rc), .rx_pair_byte_o(rxb),
        .active_line_state_o(active_line_state), .idle_line_state_o(idle_line_state));
    // clock enable driven by the bench so freezing is exercised
    fpsc_codec dut (.ref_clk_i(clk), .resetn_i(rstn), .clk_en_i(en),
        .rx_pair_parity_i(rp), .rx_pair_ctrl_flag_i(rc), .rx_pair_byte_i(rxb),
        .active_line_state_i(active_line_state), .idle_line_state_i(idle_line_state), .rx_byte_o(rxo),
        .rx_class_o(cls), .line_invalid_indication_o(inv), .rx_code_violation_o(vio),
        .tx_req_valid_i(vld), .tx_req_ready_o(rdy), .tx_req_kind_i(rk), .tx_req_byte_i(rb),
        .tx_hold_i(hold), .tx_pair_parity_o(tp), .tx_pair_ctrl_flag_o(tc),
        .tx_pair_byte_o(txb), .tx_reject_o(rej));
    // =====
    // helpers
    // =====
    task automatic chk(input bit ok, input string m);
        checks_done++;
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // model word, one edge into pins, two more to the decode
    task automatic rx(input logic c, input logic [7:0] b, input logic bad, input logic [1:0] ls,
            input fpsc_pkg::fpsc_rx_class_t e);
        @(posedge clk);
        mc <= c;
        mb <= b;
        mbad <= bad;
        mls <= ls;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(cls === e && rxo === b && inv === (e == fpsc_pkg::FPSC_RX_INVALID) &&
            vio === (e == fpsc_pkg::FPSC_RX_VIOL), "rx decode");
    endtask
    // one request, then look for its word or its refusal
    task automatic tx(input fpsc_pkg::fpsc_tx_kind_t k, input logic [7:0] b, input logic rj,
            input logic [9:0] w);
        bit hit;
        hit = 0;
        @(posedge clk);
        vld <= 1'b1;
        rk <= k;
        rb <= b;
        @(posedge clk);
        vld <= 1'b0;
        repeat (4) begin
            @(negedge clk);
            if (rj ? rej === 1'b1 : {tp, tc, txb} === w) hit = 1;
        end
        chk(hit, "tx word");
    endtask
    // =====
    // scenarios
    // =====
    task automatic test_reset();
        repeat (11) @(posedge clk);
        @(negedge clk);
        chk({tp, tc, txb} === 10'h1aa && rdy === 1'b1, "reset word");
        @(posedge clk);
        rstn <= 1'b1;
        $display("reset test done");
    endtask
    task automatic test_rx();
        rx(1'b0, 8'h00, 1'b0, 2'b11, fpsc_pkg::FPSC_RX_DATA);
        rx(1'b0, 8'hfe, 1'b0, 2'b00, fpsc_pkg::FPSC_RX_DATA);
        rx(1'b0, 8'h5a, 1'b1, 2'b11, fpsc_pkg::FPSC_RX_VIOL);
        rx(1'b1, 8'hd3, 1'b0, 2'b00, fpsc_pkg::FPSC_RX_JK);
        rx(1'b1, 8'h34, 1'b0, 2'b11, fpsc_pkg::FPSC_RX_INVALID);
        rx(1'b1, 8'hb2, 1'b0, 2'b11, fpsc_pkg::FPSC_RX_INVALID);
        rx(1'b1, 8'h9f, 1'b0, 2'b10, fpsc_pkg::FPSC_RX_IDLE);
        rx(1'b1, 8'h8f, 1'b0, 2'b01, fpsc_pkg::FPSC_RX_IDLE);
        rx(1'b1, 8'ha0, 1'b0, 2'b00, fpsc_pkg::FPSC_RX_INVALID);
        rx(1'b1, 8'h09, 1'b0, 2'b11, fpsc_pkg::FPSC_RX_DATA_IDLE);
        rx(1'b1, 8'h05, 1'b0, 2'b11, fpsc_pkg::FPSC_RX_MIXED);
        rx(1'b1, 8'h66, 1'b1, 2'b11, fpsc_pkg::FPSC_RX_FS);
        rx(1'b1, 8'h56, 1'b0, 2'b11, fpsc_pkg::FPSC_RX_ED);
        rx(1'b1, 8'h30, 1'b0, 2'b11, fpsc_pkg::FPSC_RX_VIOL);
        $display("rx test done");
    endtask
    task automatic test_tx();
        tx(fpsc_pkg::FPSC_TX_DATA, 8'h00, 1'b0, 10'h200);
        tx(fpsc_pkg::FPSC_TX_DATA, 8'h01, 1'b0, 10'h001);
        tx(fpsc_pkg::FPSC_TX_JK, 8'h00, 1'b0, 10'h1dd);
        tx(fpsc_pkg::FPSC_TX_FS, 8'h66, 1'b0, 10'h166);
        tx(fpsc_pkg::FPSC_TX_FS, 8'h77, 1'b0, 10'h177);
        tx(fpsc_pkg::FPSC_TX_FS, 8'h67, 1'b1, 10'h000);
        tx(fpsc_pkg::FPSC_TX_FS, 8'h46, 1'b1, 10'h000);
        tx(fpsc_pkg::FPSC_TX_FS_RPT, 8'h67, 1'b0, 10'h367);
        tx(fpsc_pkg::FPSC_TX_FS_RPT, 8'h75, 1'b0, 10'h375);
        tx(fpsc_pkg::FPSC_TX_ED, 8'h06, 1'b0, 10'h156);
        tx(fpsc_pkg::FPSC_TX_ED, 8'h07, 1'b0, 10'h357);
        tx(fpsc_pkg::FPSC_TX_ED, 8'h05, 1'b0, 10'h155);
        tx(fpsc_pkg::FPSC_TX_ED, 8'h08, 1'b1, 10'h000);
        $display("tx test done");
    endtask
    // stall, fill past full, then drain in order
    task automatic test_fill();
        int n;
        n = 0;
        @(posedge clk);
        hold <= 1'b1;
        for (int i = 0; i < 33; i++) begin
            @(posedge clk);
            vld <= 1'b1;
            rk <= fpsc_pkg::FPSC_TX_DATA;
            rb <= 8'(i);
        end
        @(negedge clk);
        chk(rdy === 1'b0 && {tp, tc, txb} === 10'h1aa, "full or stalled");
        @(posedge clk);
        vld <= 1'b0;
        hold <= 1'b0;
        repeat (40) begin
            @(negedge clk);
            if (tc === 1'b0) begin
                chk(txb === 8'(n), "drain order");
                n++;
            end
        end
        chk(n == 32, "drain count");
        $display("fill test done");
    endtask
    // drop the enable: outputs and buffer stand still, then resume
    task automatic test_freeze();
        @(posedge clk);
        en <= 1'b0;
        mc <= 1'b0;
        mb <= 8'h3c;
        vld <= 1'b1;
        rk <= fpsc_pkg::FPSC_TX_DATA;
        rb <= 8'hc3;
        repeat (4) @(posedge clk);
        vld <= 1'b0;
        en <= 1'b1;
        @(negedge clk);
        chk(rxo === 8'h30 && cls === fpsc_pkg::FPSC_RX_VIOL && rdy === 1'b1 &&
            {tp, tc, txb} === 10'h1aa, "frozen outputs moved");
        @(posedge clk);
        @(negedge clk);
        chk({tp, tc, txb} === 10'h1aa, "word pushed while frozen");
        @(posedge clk);
        @(negedge clk);
        chk(rxo === 8'h3c && cls === fpsc_pkg::FPSC_RX_DATA, "no decode after resume");
        $display("freeze test done");
    endtask
    initial begin
        test_reset();
        test_rx();
        test_tx();
        test_fill();
        test_freeze();
        print_verdict();
    end
    // all tests take well under 400 cycles
    initial begin
        #20000;
        error_cnt++;
        print_verdict();
    end
endmodule
